// [shared/e1rs_regs.svh]
// Register offsets, field positions and timing figures of the receive status block.
// Assumes an 8-bit register port and a 25 MHz framer clock.
`ifndef E1RS_REGS_SVH
`define E1RS_REGS_SVH
`define E1RS_ADDR_W         4
`define E1RS_OFS_CTRL0      4'h0
`define E1RS_OFS_CTRL1      4'h1
`define E1RS_OFS_DELAY      4'h2
`define E1RS_OFS_STAT0      4'h3
`define E1RS_OFS_STAT1      4'h4
`define E1RS_OFS_SPARE      4'h5
`define E1RS_OFS_EVENT      4'h6
`define E1RS_CTRL0_RST      8'h00
`define E1RS_CTRL1_RST      8'h00
`define E1RS_ZERO8          8'h00
`define E1RS_B_FOUR_ERR     0
`define E1RS_B_SW_CHECK     1
`define E1RS_B_FMT_LO       2
`define E1RS_B_FMT_HI       3
`define E1RS_B_ALARM_SIM    4
`define E1RS_B_DUAL_RAIL    5
`define E1RS_B_AUTO_TRI_DIS 6
`define E1RS_B_TX_TRI       7
`define E1RS_B_FORCE_RS     0
`define E1RS_B_MF_FORCE_RS  1
`define E1RS_B_FREEZE       2
`define E1RS_B_PRBS_EN      3
`define E1RS_B_BUF_SIZE     4
`define E1RS_FMT_INTERWORK  2'h3
`define E1RS_ERR_THR3       3'h3
`define E1RS_ERR_THR4       3'h4
`define E1RS_MF_GOOD_NEED   2'h2
`define E1RS_SHORT_PULSES   2'h3
`define E1RS_SHORT_WAIT     8'h80
`define E1RS_OPEN_ZEROS     6'h20
`define E1RS_UPD_BITS_BIG   10'h200
`define E1RS_UPD_BITS_SMALL 10'h100
`define E1RS_SLOT_MAX       6'h3F
`define E1RS_PRBS_WIN       6'h20
`define E1RS_PRBS_MAX_ERR   6'h08
`define E1RS_NMF_TIME_MS    400
`define E1RS_CLK_KHZ        25000
`endif

// [shared/e1rs_pkg.sv]
// Types shared by the receive status block and its bench.
// Assumes the constants header is included alongside.
package e1rs_pkg;
  typedef enum logic [1:0] {
    E1RS_SYNC   = 2'b00,
    E1RS_HUNT   = 2'b01,
    E1RS_WAIT_S = 2'b10,
    E1RS_WAIT_F = 2'b11
  } e1rs_fa_e;
  typedef struct packed {
    logic fas_strobe;
    logic fas_good;
    logic sw_strobe;
    logic sw_good;
    logic sw_bit3;
    logic mf_end;
    logic mf_error;
  } e1rs_rx_ev_s;
  typedef struct packed {
    logic prbs_change;
    logic tx_line_change;
    logic mf_recovery;
    logic ra_recovery;
    logic ra;
    logic align_recovery;
    logic align_loss;
  } e1rs_evt_s;
endpackage

// [hw/e1rs_top.sv]
// Receive sync status block: frame and multiframe alignment, alarms, line checks.
// Assumes framer event strobes are one cycle long and synchronous to mclk.
//
// Summary of operation
// - Loss flag sets after 3 or 4 bad alignment words, or bad service words.
// - Rising loss flag sets the alignment loss event bit.
// - Two control bits pick 3/4 error threshold and service word checking.
// - Resync needs good alignment, good service word bit2, good alignment again.
// - Loss flag clearing sets the alignment recovery event bit.
// - Multiframe lost with frame loss; multiframe hunt starts after frame regain.
// - Two error-free CRC multiframes clear the multiframe loss flag.
// - Doubleframe holds multiframe loss set; force commands or frame loss set it.
// - Multiframe loss flag clearing sets the multiframe recovery event bit.
// - Alarm simulation forces loss flag; release needs simulation off and sync.
// - Service word bit 3 sets remote alarm flag and its event bit.
// - Remote alarm clearing sets the remote alarm recovery event bit.
// - Remote alarm mirrored in spare register; simulation sets flag and event.
// - Interworking: no multiframe within 400 ms sets flag, switches to doubleframe.
// - No-multiframe flag clears whenever frame alignment is lost.
// - Ternary mode: 3 shorted pulses flag short, tristate unless disabled.
// - After 128 pulse periods retry outputs; clear short once gone.
// - Short flag changes raise line event; tristate bit freezes line flags.
// - 32 transmitted zeros set open flag, next pulse clears; rise raises event.
// - Buffer delay is 6-bit slots, updated every 512 or 256 bits.
// - Freeze request holds delay until read; invalid when buffer bypassed.
// - PRBS lock flag tolerates 10^-1 errors; every change raises event.
`timescale 1ns/1ps
`include "e1rs_regs.svh"
module e1rs_top
  import e1rs_pkg::*;
#(
  parameter int NMF_CYCLES = `E1RS_NMF_TIME_MS * `E1RS_CLK_KHZ
)(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic [`E1RS_ADDR_W-1:0]  addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [7:0]               rd_data,
  input  wire e1rs_rx_ev_s              rx_ev,
  input  wire logic                     tx_pulse_tick,
  input  wire logic                     tx_mark,
  input  wire logic                     short_detect,
  input  wire logic                     rx_bit_tick,
  input  wire logic [9:0]               buf_fill_bits,
  input  wire logic                     buf_bypass,
  input  wire logic                     prbs_bit_tick,
  input  wire logic                     prbs_bit_err,
  output logic                          tx_line_out_a_oe,
  output logic                          tx_line_out_b_oe
);
  localparam int NMF_W = $clog2(NMF_CYCLES + 1);

  // ==========================================================
  // Register port.
  logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, rd_data_d;
  e1rs_evt_s  evt_q, evt_d, evt_set;
  logic       four_error_loss_sel, service_word_check_sel;
  logic [1:0] rx_frame_format;
  logic       alarm_simulation, dual_rail_sel;
  logic       auto_tristate_disable, tx_line_tristate;
  logic       delay_freeze_req, prbs_monitor_enable, buffer_size_sel;
  logic       force_resync_cmd, multiframe_force_resync_cmd;
  logic       wr_c0, wr_c1, rd_dly, rd_evt;

  assign four_error_loss_sel         = ctrl0_q[`E1RS_B_FOUR_ERR];
  assign service_word_check_sel      = ctrl0_q[`E1RS_B_SW_CHECK];
  assign rx_frame_format             = ctrl0_q[`E1RS_B_FMT_HI:`E1RS_B_FMT_LO];
  assign alarm_simulation            = ctrl0_q[`E1RS_B_ALARM_SIM];
  assign dual_rail_sel               = ctrl0_q[`E1RS_B_DUAL_RAIL];
  assign auto_tristate_disable       = ctrl0_q[`E1RS_B_AUTO_TRI_DIS];
  assign tx_line_tristate            = ctrl0_q[`E1RS_B_TX_TRI];
  assign force_resync_cmd            = ctrl1_q[`E1RS_B_FORCE_RS];
  assign multiframe_force_resync_cmd = ctrl1_q[`E1RS_B_MF_FORCE_RS];
  assign delay_freeze_req            = ctrl1_q[`E1RS_B_FREEZE];
  assign prbs_monitor_enable         = ctrl1_q[`E1RS_B_PRBS_EN];
  assign buffer_size_sel             = ctrl1_q[`E1RS_B_BUF_SIZE];
  assign wr_c0  = wr_en && addr == `E1RS_OFS_CTRL0;
  assign wr_c1  = wr_en && addr == `E1RS_OFS_CTRL1;
  assign rd_dly = rd_en && addr == `E1RS_OFS_DELAY;
  assign rd_evt = rd_en && addr == `E1RS_OFS_EVENT;

  // ==========================================================
  // Frame alignment.
  e1rs_fa_e   fa_q, fa_d;
  logic [2:0] fas_bad_q, fas_bad_d, sw_bad_q, sw_bad_d, thr;
  logic       lfa_q, lfa_d;

  always_comb
  begin
    fa_d      = fa_q;
    fas_bad_d = fas_bad_q;
    sw_bad_d  = sw_bad_q;
    thr       = four_error_loss_sel ? `E1RS_ERR_THR4 : `E1RS_ERR_THR3;
    unique case (fa_q)
      E1RS_SYNC:
      begin
        if (rx_ev.fas_strobe)
          fas_bad_d = rx_ev.fas_good ? 3'h0 : fas_bad_q + 3'h1;
        if (rx_ev.sw_strobe && service_word_check_sel)
          sw_bad_d = rx_ev.sw_good ? 3'h0 : sw_bad_q + 3'h1;
        if (fas_bad_d >= thr || sw_bad_d >= thr)
        begin
          fa_d      = E1RS_HUNT;
          fas_bad_d = 3'h0;
          sw_bad_d  = 3'h0;
        end
      end
      E1RS_HUNT:
        if (rx_ev.fas_strobe && rx_ev.fas_good)
          fa_d = E1RS_WAIT_S;
      E1RS_WAIT_S:
        if (rx_ev.sw_strobe)
          fa_d = rx_ev.sw_good ? E1RS_WAIT_F : E1RS_HUNT;
      E1RS_WAIT_F:
        if (rx_ev.fas_strobe)
          fa_d = rx_ev.fas_good ? E1RS_SYNC : E1RS_HUNT;
    endcase
    lfa_d = alarm_simulation || fa_d != E1RS_SYNC;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fa_q      <= E1RS_HUNT;
      fas_bad_q <= 3'h0;
      sw_bad_q  <= 3'h0;
      lfa_q     <= 1'b1;
    end
    else
    begin
      fa_q      <= fa_d;
      fas_bad_q <= fas_bad_d;
      sw_bad_q  <= sw_bad_d;
      lfa_q     <= lfa_d;
    end
  end

  // ==========================================================
  // Multiframe alignment and interworking timeout.
  logic             multiframe_align_lost_q, multiframe_align_lost_d, nmf_q, nmf_d, crc_mode;
  logic [1:0]       mf_good_q, mf_good_d;
  logic [NMF_W-1:0] nmf_cnt_q, nmf_cnt_d;

  assign crc_mode = rx_frame_format[1] && !nmf_q;

  always_comb
  begin
    multiframe_align_lost_d    = multiframe_align_lost_q;
    mf_good_d = mf_good_q;
    nmf_d     = nmf_q;
    nmf_cnt_d = nmf_cnt_q;
    if (!crc_mode || lfa_q || force_resync_cmd || multiframe_force_resync_cmd)
    begin
      multiframe_align_lost_d    = 1'b1;
      mf_good_d = 2'h0;
    end
    else if (multiframe_align_lost_q && rx_ev.mf_end)
    begin
      mf_good_d = rx_ev.mf_error ? 2'h0 : mf_good_q + 2'h1;
      if (mf_good_d == `E1RS_MF_GOOD_NEED)
        multiframe_align_lost_d = 1'b0;
    end
    if (lfa_q)
    begin
      nmf_d     = 1'b0;
      nmf_cnt_d = '0;
    end
    else if (rx_frame_format == `E1RS_FMT_INTERWORK && multiframe_align_lost_q && !nmf_q)
    begin
      nmf_cnt_d = nmf_cnt_q + NMF_W'(1);
      if (nmf_cnt_d == NMF_W'(NMF_CYCLES))
        nmf_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      multiframe_align_lost_q    <= 1'b1;
      mf_good_q <= 2'h0;
      nmf_q     <= 1'b0;
      nmf_cnt_q <= '0;
    end
    else
    begin
      multiframe_align_lost_q    <= multiframe_align_lost_d;
      mf_good_q <= mf_good_d;
      nmf_q     <= nmf_d;
      nmf_cnt_q <= nmf_cnt_d;
    end
  end

  // ==========================================================
  // Remote alarm.
  logic ra_q, ra_d;

  always_comb
  begin
    ra_d = ra_q;
    if (alarm_simulation)
      ra_d = 1'b1;
    else if (lfa_q)
      ra_d = 1'b0;
    else if (rx_ev.sw_strobe)
      ra_d = rx_ev.sw_bit3;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ra_q <= 1'b0;
    else
      ra_q <= ra_d;
  end

  // ==========================================================
  // Transmit line short and open supervision.
  logic [1:0] sh_cnt_q, sh_cnt_d;
  logic [7:0] sh_wait_q, sh_wait_d;
  logic [5:0] zero_q, zero_d;
  logic       xls_q, xls_d, xlo_q, xlo_d, drive_q, drive_d;

  always_comb
  begin
    sh_cnt_d  = sh_cnt_q;
    sh_wait_d = sh_wait_q;
    xls_d     = xls_q;
    xlo_d     = xlo_q;
    zero_d    = zero_q;
    drive_d   = drive_q;
    if (dual_rail_sel)
    begin
      xls_d    = 1'b0;
      sh_cnt_d = 2'h0;
      drive_d  = 1'b1;
    end
    else if (tx_pulse_tick && !tx_line_tristate)
    begin
      if (!xls_q)
      begin
        sh_cnt_d = short_detect ? sh_cnt_q + 2'h1 : 2'h0;
        if (sh_cnt_d == `E1RS_SHORT_PULSES)
        begin
          xls_d     = 1'b1;
          drive_d   = auto_tristate_disable;
          sh_wait_d = 8'h0;
          sh_cnt_d  = 2'h0;
        end
      end
      else if (sh_wait_q != `E1RS_SHORT_WAIT)
      begin
        sh_wait_d = sh_wait_q + 8'h1;
        if (sh_wait_d == `E1RS_SHORT_WAIT)
          drive_d = 1'b1;
      end
      else if (short_detect)
      begin
        drive_d   = auto_tristate_disable;
        sh_wait_d = 8'h0;
      end
      else
      begin
        xls_d   = 1'b0;
        drive_d = 1'b1;
      end
    end
    if (tx_pulse_tick && !tx_line_tristate)
    begin
      if (tx_mark)
      begin
        zero_d = 6'h0;
        xlo_d  = 1'b0;
      end
      else if (zero_q != `E1RS_OPEN_ZEROS)
      begin
        zero_d = zero_q + 6'h1;
        if (zero_d == `E1RS_OPEN_ZEROS)
          xlo_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_cnt_q  <= 2'h0;
      sh_wait_q <= 8'h0;
      zero_q    <= 6'h0;
      xls_q     <= 1'b0;
      xlo_q     <= 1'b0;
      drive_q   <= 1'b1;
    end
    else
    begin
      sh_cnt_q  <= sh_cnt_d;
      sh_wait_q <= sh_wait_d;
      zero_q    <= zero_d;
      xls_q     <= xls_d;
      xlo_q     <= xlo_d;
      drive_q   <= drive_d;
    end
  end

  // ==========================================================
  // Elastic buffer delay.
  logic [9:0] upd_q, upd_d, period;
  logic [5:0] dly_q, dly_d;

  function automatic logic [5:0] bits_to_slots(input logic [9:0] b);
    if (b[9:3] > 7'(`E1RS_SLOT_MAX))
      return `E1RS_SLOT_MAX;
    return b[8:3];
  endfunction

  always_comb
  begin
    upd_d  = upd_q;
    dly_d  = dly_q;
    period = buffer_size_sel ? `E1RS_UPD_BITS_SMALL : `E1RS_UPD_BITS_BIG;
    if (rx_bit_tick)
    begin
      upd_d = upd_q + 10'h1;
      if (upd_d >= period)
      begin
        upd_d = 10'h0;
        if (!delay_freeze_req && !buf_bypass)
          dly_d = bits_to_slots(buf_fill_bits);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      upd_q <= 10'h0;
      dly_q <= 6'h0;
    end
    else
    begin
      upd_q <= upd_d;
      dly_q <= dly_d;
    end
  end

  // ==========================================================
  // PRBS synchronizer.
  logic [5:0] pwin_q, pwin_d, perr_q, perr_d;
  logic       plock_q, plock_d;

  always_comb
  begin
    pwin_d  = pwin_q;
    perr_d  = perr_q;
    plock_d = plock_q;
    if (!prbs_monitor_enable)
    begin
      pwin_d  = 6'h0;
      perr_d  = 6'h0;
      plock_d = 1'b0;
    end
    else if (prbs_bit_tick)
    begin
      pwin_d = pwin_q + 6'h1;
      perr_d = perr_q + {5'h0, prbs_bit_err};
      if (pwin_d == `E1RS_PRBS_WIN)
      begin
        plock_d = perr_d < `E1RS_PRBS_MAX_ERR;
        pwin_d  = 6'h0;
        perr_d  = 6'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwin_q  <= 6'h0;
      perr_q  <= 6'h0;
      plock_q <= 1'b0;
    end
    else
    begin
      pwin_q  <= pwin_d;
      perr_q  <= perr_d;
      plock_q <= plock_d;
    end
  end

  // ==========================================================
  // Control, event and read data registers.
  always_comb
  begin
    evt_set.align_loss     = lfa_d && !lfa_q;
    evt_set.align_recovery = !lfa_d && lfa_q;
    evt_set.ra             = ra_d && !ra_q;
    evt_set.ra_recovery    = !ra_d && ra_q;
    evt_set.mf_recovery    = !multiframe_align_lost_d && multiframe_align_lost_q;
    evt_set.tx_line_change = (xls_d != xls_q) || (xlo_d && !xlo_q);
    evt_set.prbs_change    = plock_d != plock_q;
    evt_d   = (rd_evt ? '0 : evt_q) | evt_set;
    ctrl0_d = wr_c0 ? wr_data : ctrl0_q;
    ctrl1_d = wr_c1 ? wr_data : ctrl1_q;
    ctrl1_d[`E1RS_B_FORCE_RS]    = wr_c1 && wr_data[`E1RS_B_FORCE_RS];
    ctrl1_d[`E1RS_B_MF_FORCE_RS] = wr_c1 && wr_data[`E1RS_B_MF_FORCE_RS];
    if (rd_dly && !wr_c1)
      ctrl1_d[`E1RS_B_FREEZE] = 1'b0;
    rd_data_d = `E1RS_ZERO8;
    if (rd_en)
      unique case (addr)
        `E1RS_OFS_CTRL0: rd_data_d = ctrl0_q;
        `E1RS_OFS_CTRL1: rd_data_d = ctrl1_q;
        `E1RS_OFS_DELAY: rd_data_d = {2'h0, dly_q};
        `E1RS_OFS_STAT0: rd_data_d = {lfa_q, ra_q, nmf_q, multiframe_align_lost_q, 4'h0};
        `E1RS_OFS_STAT1: rd_data_d = {6'h0, xls_q, xlo_q};
        `E1RS_OFS_SPARE: rd_data_d = {3'h0, ra_q, 3'h0, plock_q};
        `E1RS_OFS_EVENT: rd_data_d = {1'b0, evt_q};
        default:         rd_data_d = `E1RS_ZERO8;
      endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl0_q          <= `E1RS_CTRL0_RST;
      ctrl1_q          <= `E1RS_CTRL1_RST;
      evt_q            <= '0;
      rd_data          <= `E1RS_ZERO8;
      tx_line_out_a_oe <= 1'b1;
      tx_line_out_b_oe <= 1'b1;
    end
    else
    begin
      ctrl0_q          <= ctrl0_d;
      ctrl1_q          <= ctrl1_d;
      evt_q            <= evt_d;
      rd_data          <= rd_data_d;
      tx_line_out_a_oe <= drive_d;
      tx_line_out_b_oe <= drive_d;
    end
  end
endmodule

// [test/e1rs_props.sv]
// Port checker of the receive status block.
// Assumes it is bound to e1rs_top and sees only its ports.
`timescale 1ns/1ps
`include "e1rs_regs.svh"
module e1rs_props
  import e1rs_pkg::*;
#(
  parameter int NMF_CYCLES = 200
)(
  input wire logic [`E1RS_ADDR_W-1:0] addr,
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire logic [7:0]              wr_data,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [7:0]              rd_data,
  input wire logic                    tx_pulse_tick,
  input wire logic                    tx_mark,
  input wire logic                    short_detect,
  input wire logic                    tx_line_out_a_oe,
  input wire logic                    tx_line_out_b_oe
);
  // ==========
  // Shadow of the control byte and of the transmit pulse history.
  logic [7:0] c0_q;
  logic [1:0] sc_q;
  logic [5:0] zc_q;
  logic       mk_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      c0_q <= 8'h00;
      sc_q <= 2'h0;
      zc_q <= 6'h00;
      mk_q <= 1'b0;
    end
    else
    begin
      if (wr_en && addr == `E1RS_OFS_CTRL0)
        c0_q <= wr_data;
      if (tx_pulse_tick)
        sc_q <= !short_detect ? 2'h0 : (sc_q == 2'h3 ? sc_q : sc_q + 2'h1);
      if (c0_q[7])
      begin
        zc_q <= 6'h00;
        mk_q <= 1'b0;
      end
      else if (tx_pulse_tick)
      begin
        zc_q <= tx_mark ? 6'h00 : (zc_q == 6'h3F ? zc_q : zc_q + 6'h01);
        mk_q <= tx_mark;
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rd_idle; !rd_en |=> rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap; rd_en && addr > `E1RS_OFS_EVENT |=> rd_data == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ctrl_rb; rd_en && addr == `E1RS_OFS_CTRL0 |=> rd_data == c0_q; endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control byte readback wrong");
  property p_dly_w; rd_en && addr == `E1RS_OFS_DELAY |=> rd_data[7:6] == 2'h0; endproperty
  a_dly_w: assert property (p_dly_w) else $error("delay wider than six bits");
  property p_cmd_clr; rd_en && addr == `E1RS_OFS_CTRL1 && !$past(wr_en) |=> rd_data[1:0] == 2'h0; endproperty
  a_cmd_clr: assert property (p_cmd_clr) else $error("resync command not cleared");
  property p_oe_pair; tx_line_out_a_oe == tx_line_out_b_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("line enables differ");
  property p_short_tri;
    tx_pulse_tick && short_detect && sc_q == 2'h2 && c0_q[7:5] == 3'h0 && tx_line_out_a_oe
      |-> ##[1:2] !tx_line_out_a_oe;
  endproperty
  a_short_tri: assert property (p_short_tri) else $error("short not tristated");
  property p_open_set; rd_en && addr == `E1RS_OFS_STAT1 && zc_q > 6'h20 |=> rd_data[0]; endproperty
  a_open_set: assert property (p_open_set) else $error("open flag missing");
  property p_open_clr; rd_en && addr == `E1RS_OFS_STAT1 && mk_q |=> !rd_data[0]; endproperty
  a_open_clr: assert property (p_open_clr) else $error("open flag stuck");
  c_tri: cover property (!tx_line_out_a_oe);
  c_open: cover property (rd_en && zc_q > 6'h20);
  c_short: cover property (rd_en && addr == `E1RS_OFS_STAT1 ##1 rd_data[1]);
endmodule
bind e1rs_top e1rs_props #(.NMF_CYCLES(NMF_CYCLES)) pr_u (.addr, .mclk, .rstn, .wr_data, .wr_en, .rd_en,
  .rd_data, .tx_pulse_tick, .tx_mark, .short_detect, .tx_line_out_a_oe, .tx_line_out_b_oe);

// [test/e1rs_line_model.sv]
// Remote line model: turns bench requests into one-cycle framer strobes.
// Assumes one request at a time; kind 0 alignment word, 1 service word, 2 multiframe end.
`timescale 1ns/1ps
module e1rs_line_model
  import e1rs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       req,
  input  wire logic [1:0] kind,
  input  wire logic       good,
  input  wire logic       bit3,
  output e1rs_rx_ev_s     rx_ev
);
  // ==========
  // Qualifiers flip between strobes so stale values are never trusted.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rx_ev <= '0;
    else
    begin
      rx_ev.fas_strobe <= req && kind == 2'h0;
      rx_ev.sw_strobe  <= req && kind == 2'h1;
      rx_ev.mf_end     <= req && kind == 2'h2;
      rx_ev.fas_good   <= req ? good : !rx_ev.fas_good;
      rx_ev.sw_good    <= req ? good : !rx_ev.sw_good;
      rx_ev.sw_bit3    <= req ? bit3 : !rx_ev.sw_bit3;
      rx_ev.mf_error   <= req ? !good : !rx_ev.mf_error;
    end
  end
endmodule

// [test/e1rs_top_tb.sv]
// Self-checking bench of the receive status block.
// Assumes the line model and the checker are compiled before it.
`timescale 1ns/1ps
`include "e1rs_regs.svh"
module e1rs_top_tb
  import e1rs_pkg::*;
;
  localparam int NO_MULTIFRAME_FOUND = 200;
  logic        mclk, rstn, wr_en, rd_en, req, good, bit3, tpt, tmk, sdet, rbt, byp, pbt, perr, oea, oeb;
  logic [3:0]  addr;
  logic [7:0]  wr_data, rd_data, v, old;
  logic [1:0]  kind;
  logic [9:0]  fill;
  e1rs_rx_ev_s rx_ev;
  int          err_total, checked, cyc, seed;
  e1rs_line_model lm_u (.mclk, .rstn, .req, .kind, .good, .bit3, .rx_ev);
  e1rs_top #(.NMF_CYCLES(NO_MULTIFRAME_FOUND)) dut_u (.mclk, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .rx_ev,
    .tx_pulse_tick(tpt), .tx_mark(tmk), .short_detect(sdet), .rx_bit_tick(rbt), .buf_fill_bits(fill),
    .buf_bypass(byp), .prbs_bit_tick(pbt), .prbs_bit_err(perr), .tx_line_out_a_oe(oea), .tx_line_out_b_oe(oeb));
  // ==========
  // Clock, bit ticks and run limit.
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    rbt <= !rbt;
    if (cyc == 80000)
    begin
      err_total++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    d = rd_data;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask
  task automatic ev(input logic [1:0] k, input logic g, input logic b);
    @(posedge mclk);
    req  <= 1'b1;
    kind <= k;
    good <= g;
    bit3 <= b;
    @(posedge mclk);
    req  <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic fr(input logic gf, input logic gs, input logic b);
    ev(2'h0, gf, 1'b0);
    ev(2'h1, gs, b);
  endtask
  task automatic tk(input logic m, input logic s, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      tpt  <= 1'b1;
      tmk  <= m;
      sdet <= s;
      @(posedge mclk);
      tpt  <= 1'b0;
    end
  endtask
  task automatic pb(input int n, input int e);
    for (int k = 0; k < n; k++)
    begin
      @(posedge mclk);
      pbt  <= 1'b1;
      perr <= (k % e) == 0;
      @(posedge mclk);
      pbt  <= 1'b0;
    end
  endtask
  function automatic logic [7:0] dexp(input logic [9:0] f);
    dexp = f[9:3] > 7'h3F ? 8'h3F : {1'b0, f[9:3]};
  endfunction
  // ==========
  // Main sequence.
  initial
  begin
    {rstn, wr_en, rd_en, req, good, bit3, tpt, tmk, sdet, rbt, byp, pbt, perr} = '0;
    {addr, wr_data, kind, fill, err_total, checked, cyc} = '0;
    seed = 88873;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rc(`E1RS_OFS_CTRL0, 8'hFF, 8'h00);
    wr(`E1RS_OFS_STAT0, 8'hFF);
    rc(`E1RS_OFS_STAT0, 8'hF0, 8'h90);
    for (int a = 7; a < 16; a++)
      rc(a[3:0], 8'hFF, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(`E1RS_OFS_CTRL0, {6'h00, m[1:0]});
      fr(1'b1, 1'b0, 1'b0);
      ev(2'h0, 1'b1, 1'b0);
      rc(`E1RS_OFS_STAT0, 8'h80, 8'h80);
      fr(1'b1, 1'b1, 1'b0);
      fr(1'b1, 1'b1, 1'b0);
      rc(`E1RS_OFS_STAT0, 8'h90, 8'h10);
      rc(`E1RS_OFS_EVENT, 8'h03, 8'h02);
      for (int i = 0; i < 3 + m[0]; i++)
      begin
        rc(`E1RS_OFS_STAT0, 8'h80, 8'h00);
        fr(m[1], !m[1], 1'b0);
      end
      rc(`E1RS_OFS_STAT0, 8'h80, 8'h80);
      rc(`E1RS_OFS_EVENT, 8'h01, 8'h01);
    end
    fr(1'b1, 1'b1, 1'b0);
    fr(1'b1, 1'b1, 1'b0);
    rd(`E1RS_OFS_EVENT, v);
    fr(1'b1, 1'b1, 1'b1);
    rc(`E1RS_OFS_STAT0, 8'h40, 8'h40);
    rc(`E1RS_OFS_SPARE, 8'h10, 8'h10);
    rc(`E1RS_OFS_EVENT, 8'h0C, 8'h04);
    fr(1'b1, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'h40, 8'h00);
    rc(`E1RS_OFS_EVENT, 8'h0C, 8'h08);
    wr(`E1RS_OFS_CTRL0, 8'h10);
    rc(`E1RS_OFS_STAT0, 8'hC0, 8'hC0);
    rc(`E1RS_OFS_EVENT, 8'h04, 8'h04);
    wr(`E1RS_OFS_CTRL0, 8'h08);
    fr(1'b1, 1'b1, 1'b0);
    fr(1'b1, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'hD0, 8'h10);
    rd(`E1RS_OFS_EVENT, v);
    ev(2'h2, 1'b1, 1'b0);
    ev(2'h2, 1'b0, 1'b0);
    ev(2'h2, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'h10, 8'h10);
    ev(2'h2, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'h10, 8'h00);
    rc(`E1RS_OFS_EVENT, 8'h10, 8'h10);
    wr(`E1RS_OFS_CTRL1, 8'h02);
    rc(`E1RS_OFS_STAT0, 8'h10, 8'h10);
    rc(`E1RS_OFS_CTRL1, 8'h03, 8'h00);
    repeat (2) ev(2'h2, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'h10, 8'h00);
    wr(`E1RS_OFS_CTRL1, 8'h01);
    rc(`E1RS_OFS_STAT0, 8'h10, 8'h10);
    repeat (3) fr(1'b0, 1'b1, 1'b0);
    repeat (2) ev(2'h2, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'h90, 8'h90);
    wr(`E1RS_OFS_CTRL0, 8'h0C);
    repeat (2) fr(1'b1, 1'b1, 1'b0);
    repeat (NO_MULTIFRAME_FOUND + 50) @(posedge mclk);
    repeat (2) ev(2'h2, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'hB0, 8'h30);
    repeat (3) fr(1'b0, 1'b1, 1'b0);
    rc(`E1RS_OFS_STAT0, 8'h20, 8'h00);
    wr(`E1RS_OFS_CTRL0, 8'h00);
    rd(`E1RS_OFS_EVENT, v);
    tk(1'b1, 1'b1, 2);
    repeat (2) @(negedge mclk);
    chk({6'h00, oea, oeb}, 8'h03);
    tk(1'b1, 1'b1, 1);
    repeat (2) @(negedge mclk);
    chk({6'h00, oea, oeb}, 8'h00);
    rc(`E1RS_OFS_STAT1, 8'h02, 8'h02);
    rc(`E1RS_OFS_EVENT, 8'h20, 8'h20);
    tk(1'b1, 1'b1, 130);
    @(negedge mclk);
    chk({6'h00, oea, oeb}, 8'h00);
    tk(1'b1, 1'b0, 260);
    @(negedge mclk);
    chk({6'h00, oea, oeb}, 8'h03);
    rc(`E1RS_OFS_STAT1, 8'h02, 8'h00);
    rc(`E1RS_OFS_EVENT, 8'h20, 8'h20);
    tk(1'b0, 1'b0, 40);
    rc(`E1RS_OFS_STAT1, 8'h01, 8'h01);
    rc(`E1RS_OFS_EVENT, 8'h20, 8'h20);
    tk(1'b1, 1'b0, 1);
    rc(`E1RS_OFS_STAT1, 8'h01, 8'h00);
    wr(`E1RS_OFS_CTRL0, 8'h80);
    tk(1'b0, 1'b0, 40);
    rc(`E1RS_OFS_STAT1, 8'h01, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(`E1RS_OFS_CTRL1, {3'h0, i[0], 4'h0});
      fill <= i == 0 ? 10'h007 : (i == 1 ? 10'h3FF : 10'($random(seed)));
      repeat (1100) @(posedge mclk);
      old = dexp(fill);
      rc(`E1RS_OFS_DELAY, 8'hFF, old);
      wr(`E1RS_OFS_CTRL1, {3'h0, i[0], 4'h4});
      fill <= 10'($random(seed));
      repeat (1100) @(posedge mclk);
      rc(`E1RS_OFS_DELAY, 8'hFF, old);
      repeat (1100) @(posedge mclk);
      rc(`E1RS_OFS_DELAY, 8'hFF, dexp(fill));
    end
    old = dexp(fill);
    @(posedge mclk);
    byp  <= 1'b1;
    fill <= 10'h0FF;
    repeat (1100) @(posedge mclk);
    rc(`E1RS_OFS_DELAY, 8'hFF, old);
    wr(`E1RS_OFS_CTRL1, 8'h08);
    rd(`E1RS_OFS_EVENT, v);
    pb(96, 10);
    rc(`E1RS_OFS_SPARE, 8'h01, 8'h01);
    rc(`E1RS_OFS_EVENT, 8'h40, 8'h40);
    pb(96, 2);
    rc(`E1RS_OFS_SPARE, 8'h01, 8'h00);
    pb(96, 1000);
    rc(`E1RS_OFS_SPARE, 8'h01, 8'h01);
    complete_run;
  end
endmodule
